// ===== verilog/hbdfl_pkg.sv
package hbdfl_pkg;
   // System clock rate in kHz.
   localparam int unsigned CLK_KHZ         = 25000;
   // Dead time inserted on a direction reversal, in ns.
   localparam int unsigned DEAD_NS         = 2000;
   // Dead time as a cycle count, rounded up.
   localparam int unsigned DEAD_CYC        =
      (DEAD_NS * (CLK_KHZ / 1000) + 999) / 1000;
   // Narrowest enable pulse the device follows, in ns.
   localparam int unsigned MIN_PULSE_NS    = 1000;
   // Narrowest pulse in cycles, rounded up.
   localparam int unsigned MIN_PULSE_CYC   =
      (MIN_PULSE_NS * (CLK_KHZ / 1000) + 999) / 1000;
   // Least enable high width for a guaranteed short check, in ns.
   localparam int unsigned SC_WIDTH_NS     = 16000;
   // That width in cycles, rounded up.
   localparam int unsigned SC_WIDTH_CYC    =
      (SC_WIDTH_NS * (CLK_KHZ / 1000) + 999) / 1000;
   // Internal chopping off-time in cycles (one period near 46 kHz).
   localparam int unsigned CHOP_OFF_CYC    = 543;
   // Counter width that covers every count above.
   localparam int unsigned CNT_W           = 10;
   // Drive states of the bridge.
   typedef enum logic [2:0] {
      HBDFL_STOP, HBDFL_FWD, HBDFL_REV, HBDFL_BRK_LO, HBDFL_BRK_HI
   } hbdfl_mode_t;
endpackage

// ===== verilog/hbdfl_if.sv
`timescale 1ns/1ns
// Pins between the host controller and the bridge logic.
interface hbdfl_if;
   logic dirInputA;  // Direction input, leg A.
   logic dirInputB;  // Direction input, leg B.
   logic enable;     // Drive enable, may carry PWM.
   logic faultN;     // Latched fault, active low.
   // Bridge device end.
   modport device (input dirInputA, input dirInputB, input enable,
                   output faultN);
   // Host controller end.
   modport host (output dirInputA, output dirInputB, output enable,
                 input faultN);
endinterface

// ===== verilog/hbdfl_host.sv
`timescale 1ns/1ns
// Host end: turns a user command into pin levels, keeps pulses legal outside supply ramps.
module hbdfl_host (
   input  wire logic                sys_clk,      // System clock.
   input  wire logic                rst_n,        // Synchronous reset.
   input  wire logic                supplyRampN,  // Low while supply ramps.
   input  wire hbdfl_pkg::hbdfl_mode_t cmdMode,   // Requested mode.
   input  wire logic                cmdPwm,       // PWM level for enable.
   output logic                     faultSeenN,   // Fault pin, registered.
   hbdfl_if.host                    pins          // Pins to the device.
);
   // Width counter for the enable level now on the pin.
   logic [hbdfl_pkg::CNT_W-1:0] widthCnt_ff;
   logic [hbdfl_pkg::CNT_W-1:0] nxt_widthCnt;
   logic aOut_ff, bOut_ff, enOut_ff, faultSeenN_ff;
   // Wanted enable level from the command. High brake needs enable high
   // as well, so it counts as driving.
   wire  drive = (cmdMode == hbdfl_pkg::HBDFL_FWD) ||
                 (cmdMode == hbdfl_pkg::HBDFL_REV) ||
                 (cmdMode == hbdfl_pkg::HBDFL_BRK_HI);
   wire  wantEn = supplyRampN && drive && cmdPwm;
   // Outside a supply ramp, the level may change only after the least width has passed.
   wire  mayFlip = (widthCnt_ff >=
                    hbdfl_pkg::CNT_W'(hbdfl_pkg::MIN_PULSE_CYC - 1));
   wire  nxtEn = (!supplyRampN) ? 1'b0 :
                 (mayFlip ? wantEn : enOut_ff);
   // Stop is sent as both inputs high for the lowest loss.
   wire  nxtA = (cmdMode == hbdfl_pkg::HBDFL_FWD) ||
                (cmdMode == hbdfl_pkg::HBDFL_STOP) ||
                (cmdMode == hbdfl_pkg::HBDFL_BRK_HI);
   wire  nxtB = (cmdMode == hbdfl_pkg::HBDFL_REV) ||
                (cmdMode == hbdfl_pkg::HBDFL_STOP) ||
                (cmdMode == hbdfl_pkg::HBDFL_BRK_HI);
   always_comb begin
      // Restart the width count on every enable edge.
      if (nxtEn != enOut_ff) begin
         nxt_widthCnt = '0;
      end else if (mayFlip) begin
         nxt_widthCnt = widthCnt_ff;
      end else begin
         nxt_widthCnt = widthCnt_ff + 1'b1;
      end
   end
   // Register all pins so they leave from flip-flops.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aOut_ff       <= 1'b1;
         bOut_ff       <= 1'b1;
         enOut_ff      <= 1'b0;
         widthCnt_ff   <= '0;
         faultSeenN_ff <= 1'b1;
      end else begin
         aOut_ff       <= nxtA;
         bOut_ff       <= nxtB;
         enOut_ff      <= nxtEn;
         widthCnt_ff   <= nxt_widthCnt;
         faultSeenN_ff <= pins.faultN;
      end
   end
   assign pins.dirInputA = aOut_ff;
   assign pins.dirInputB = bOut_ff;
   assign pins.enable    = enOut_ff;
   assign faultSeenN     = faultSeenN_ff;
endmodule // hbdfl_host

// ===== verilog/hbdfl_device.sv
`timescale 1ns/1ns
// Summary of operation
// - Input A low: A high on, else low on.
// - Input B low: B high on, else low on.
// - Enable low, inputs not both low: stop.
// - Dead time inserted internally on reversal.
// - Both inputs low: brake, ground-side gates asserted.
// - Host stops with inputs high, enable low.
// - Host holds enable high to drive.
// - Enable gates drive, carries external PWM.
// - Host keeps PWM pulses at least 1 us; a supply ramp here drops enable at once.
// - Short check sure only for 16 us highs.
// - Host holds enable low during supply ramps.
// - Supply falling with enable high raises fault.
// - Any detector: fault low, all switches latched off.
// - Output short to supply or ground detected.
// - Only supply power cycle clears the latch.
// - Chop low sides when current hits limit.
// - Sense voltage over threshold trips overcurrent.
// - Shorted sense resistor gives no overcurrent trip.
// - All detectors share one shutdown latch.
module hbdfl_device #(
   parameter int unsigned DEAD_CYC     = hbdfl_pkg::DEAD_CYC,
   parameter int unsigned SC_WIDTH_CYC = hbdfl_pkg::SC_WIDTH_CYC,
   parameter int unsigned CHOP_OFF_CYC = hbdfl_pkg::CHOP_OFF_CYC
) (
   input  wire logic sys_clk,         // System clock.
   input  wire logic rst_n,           // Control supply power-on reset.
   input  wire logic supplyLow,       // Control supply under threshold.
   input  wire logic outShortDet,     // Output shorted to supply or ground.
   input  wire logic senseOverThr,    // Sense voltage above trip threshold.
   input  wire logic senseShorted,    // Sense resistor found shorted.
   input  wire logic overheatDet,     // Substrate overheated.
   input  wire logic currentAtLimit,  // Sensed current at the set peak.
   output logic      hsSwitchLegA,    // High side, leg A.
   output logic      lsSwitchLegA,    // Low side, leg A.
   output logic      hsSwitchLegB,    // High side, leg B.
   output logic      lsSwitchLegB,    // Low side, leg B.
   hbdfl_if.device   pins             // Pins from the host.
);
   // Refuse counts the counters cannot hold.
   if (DEAD_CYC < 1 || DEAD_CYC >= (1 << hbdfl_pkg::CNT_W) ||
       SC_WIDTH_CYC >= (1 << hbdfl_pkg::CNT_W) ||
       CHOP_OFF_CYC < 1 || CHOP_OFF_CYC >= (1 << hbdfl_pkg::CNT_W)) begin
      $error("hbdfl_device: count parameter out of range");
   end

   // Latched shutdown state, set by any detector, freed by reset only.
   logic                        faultLatch_ff;
   // Registered fault pin, so the pin leaves a flip-flop.
   logic                        faultN_ff;
   // Mode the legs are driven in now.
   hbdfl_pkg::hbdfl_mode_t      mode_ff;
   // Dead-time count and its next value.
   logic [hbdfl_pkg::CNT_W-1:0] deadCnt_ff;
   logic [hbdfl_pkg::CNT_W-1:0] nxt_deadCnt;
   // Width of the present enable high pulse.
   logic [hbdfl_pkg::CNT_W-1:0] enHighCnt_ff;
   // Off time left in the low-side chop.
   logic [hbdfl_pkg::CNT_W-1:0] chopCnt_ff;
   // Switch drive registers, one per bridge switch.
   logic                        hsA_ff;       // High side, leg A.
   logic                        lsA_ff;       // Low side, leg A.
   logic                        hsB_ff;       // High side, leg B.
   logic                        lsB_ff;       // Low side, leg B.

   // Short check is qualified by a long enough enable high; narrower
   // pulses may let a short go unseen.
   wire scQualified = (enHighCnt_ff >=
                       hbdfl_pkg::CNT_W'(SC_WIDTH_CYC));
   // Output shorted to either rail while the bridge is driven.
   wire shortTrip = outShortDet && pins.enable && scQualified;
   // Over the sense threshold, unless the sense resistor is shorted.
   wire ocTrip    = senseOverThr && !senseShorted;
   // Control supply sagging while the bridge is enabled.
   wire uvTrip    = supplyLow && pins.enable;
   // One latch serves every detector.
   wire anyTrip   = shortTrip || ocTrip || overheatDet || uvTrip;

   // Decode the pins into a mode.
   // Both inputs low asks for the ground-side brake.
   wire bothLow  = !pins.dirInputA && !pins.dirInputB;
   // Both inputs high with enable high asks for the supply-side brake.
   wire bothHigh = pins.dirInputA && pins.dirInputB;
   // Mode the pins ask for this cycle.
   hbdfl_pkg::hbdfl_mode_t reqMode;
   assign reqMode = bothLow ? hbdfl_pkg::HBDFL_BRK_LO :
                    !pins.enable ? hbdfl_pkg::HBDFL_STOP :
                    bothHigh ? hbdfl_pkg::HBDFL_BRK_HI :
                    pins.dirInputA ? hbdfl_pkg::HBDFL_FWD :
                    hbdfl_pkg::HBDFL_REV;
   // Every mode change waits out the dead time, so a reversal never has
   // both switches of a leg on together and the host need not pass
   // through stop first.
   wire modeChange = (reqMode != mode_ff);
   // The dead count has run out.
   wire deadDone   = (deadCnt_ff == '0);
   always_comb begin
      if (modeChange && deadDone) begin
         // A new mode is asked for: arm the full dead time.
         nxt_deadCnt = hbdfl_pkg::CNT_W'(DEAD_CYC);
      end else if (!deadDone) begin
         // Dead time running: count it down.
         nxt_deadCnt = deadCnt_ff - 1'b1;
      end else begin
         // Settled: nothing to count.
         nxt_deadCnt = deadCnt_ff;
      end
   end
   // All switches off while a change is pending or the count runs.
   wire inDead  = !deadDone || modeChange;
   // Chop holds the input-driven low sides off for a fixed time after the limit; low brake ignores it.
   wire chopOff = (chopCnt_ff != '0);
   // Supply-side switch of one leg: on while its input is low, and in
   // high brake, where both supply sides carry the motor current.
   function automatic logic legHigh(input logic dirIn, input logic brkL,
                                    input logic brkH);
      legHigh = !brkL && (brkH || !dirIn);
   endfunction
   // Ground-side switch of one leg: on while its input is high unless the
   // chop holds it off, and in low brake, where both ground sides conduct.
   function automatic logic legLow(input logic dirIn, input logic brkL,
                                   input logic brkH, input logic chop);
      legLow = !brkH && (brkL || (dirIn && !chop));
   endfunction
   // Legs may conduct only outside shutdown and outside the dead time.
   wire legOn   = !faultLatch_ff && !inDead;
   // Stop leaves every switch off.
   wire drvOn   = legOn && (mode_ff != hbdfl_pkg::HBDFL_STOP);
   // In low brake the ground sides conduct; in high brake the supply
   // sides do, and neither leg follows its own input then.
   wire brkLo   = (mode_ff == hbdfl_pkg::HBDFL_BRK_LO);
   wire brkHi   = (mode_ff == hbdfl_pkg::HBDFL_BRK_HI);
   // Next level of each switch, before the trip override.
   wire nxtHsA  = drvOn && legHigh(pins.dirInputA, brkLo, brkHi);
   wire nxtLsA  = drvOn &&
                  legLow(pins.dirInputA, brkLo, brkHi, chopOff);
   wire nxtHsB  = drvOn && legHigh(pins.dirInputB, brkLo, brkHi);
   wire nxtLsB  = drvOn &&
                  legLow(pins.dirInputB, brkLo, brkHi, chopOff);

   // Fault latch: set by any detector, cleared only by reset. The pin
   // copy moves on the same edge, so it never disagrees with the latch.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // Power-on reset is the only way out of shutdown.
         faultLatch_ff <= 1'b0;
         faultN_ff     <= 1'b1;
      end else if (anyTrip) begin
         // A detector fired: shut down and hold until reset.
         faultLatch_ff <= 1'b1;
         faultN_ff     <= 1'b0;
      end
   end
   // Mode and dead-time tracking.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // Start in stop with nothing pending.
         mode_ff    <= hbdfl_pkg::HBDFL_STOP;
         deadCnt_ff <= '0;
      end else begin
         deadCnt_ff <= nxt_deadCnt;
         if (modeChange && deadDone) begin
            // Take the new mode as the dead time is armed; the legs stay
            // off until the count runs out.
            mode_ff <= reqMode;
         end
      end
   end
   // Enable high width, saturating at the qualifying count.
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !pins.enable) begin
         // A low enable restarts the measure.
         enHighCnt_ff <= '0;
      end else if (!scQualified) begin
         // Count up to the qualifying width, then hold.
         enHighCnt_ff <= enHighCnt_ff + 1'b1;
      end
   end
   // Chop off-timer, started when the current reaches its limit.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         chopCnt_ff <= '0;
      end else if (chopOff) begin
         // Off time running: the low sides stay off, except in low brake.
         chopCnt_ff <= chopCnt_ff - 1'b1;
      end else if (currentAtLimit) begin
         // Current reached its peak: start a fresh off time.
         chopCnt_ff <= hbdfl_pkg::CNT_W'(CHOP_OFF_CYC);
      end
   end
   // Switch outputs leave from flip-flops. A trip clears them on the
   // same edge that sets the latch, so no switch outlives the fault by
   // a cycle.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // Every switch off while the control supply comes up.
         hsA_ff <= 1'b0;
         lsA_ff <= 1'b0;
         hsB_ff <= 1'b0;
         lsB_ff <= 1'b0;
      end else begin
         // Follow the decode unless a detector fires now.
         hsA_ff <= nxtHsA && !anyTrip;
         lsA_ff <= nxtLsA && !anyTrip;
         hsB_ff <= nxtHsB && !anyTrip;
         lsB_ff <= nxtLsB && !anyTrip;
      end
   end
   // Pins and switch gates come straight from the registers above.
   assign hsSwitchLegA = hsA_ff;
   assign lsSwitchLegA = lsA_ff;
   assign hsSwitchLegB = hsB_ff;
   assign lsSwitchLegB = lsB_ff;
   assign pins.faultN  = faultN_ff;
endmodule // hbdfl_device

// ===== sim/hbdfl_asserts.sv
`timescale 1ns/1ns
// Watches the pins and the switch drive of the bridge pair.
module hbdfl_asserts #(
   parameter int unsigned DEAD_CYC = hbdfl_pkg::DEAD_CYC // Dead cycles.
) (
   input wire logic sys_clk,      // System clock.
   input wire logic rst_n,        // Synchronous reset.
   input wire logic dirInputA,    // Direction, leg A.
   input wire logic dirInputB,    // Direction, leg B.
   input wire logic enable,       // Drive enable.
   input wire logic faultN,       // Latched fault.
   input wire logic hsSwitchLegA, // High side, leg A.
   input wire logic lsSwitchLegA, // Low side, leg A.
   input wire logic hsSwitchLegB, // High side, leg B.
   input wire logic lsSwitchLegB  // Low side, leg B.
);
   localparam int unsigned MINP = hbdfl_pkg::MIN_PULSE_CYC; // Least pulse.
   int unsigned runLen_ff; // Edges since enable last changed.
   int unsigned offLen_ff; // Edges with every switch off.
   wire anyOn = hsSwitchLegA | lsSwitchLegA | hsSwitchLegB | lsSwitchLegB;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Reset counts as a long level, so the first change is never flagged.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) runLen_ff <= MINP;
      else if ($changed(enable)) runLen_ff <= 0;
      else if (runLen_ff < MINP) runLen_ff <= runLen_ff + 1;
   end
   // Measures each all-off gap, saturating well above the dead time.
   always_ff @(posedge sys_clk) begin
      if (!rst_n || anyOn) offLen_ff <= 0;
      else if (offLen_ff < 1000) offLen_ff <= offLen_ff + 1;
   end
   chk_leg_a_follow: assert property (
      $rose(hsSwitchLegA) && !hsSwitchLegB |-> !$past(dirInputA))
      else $error("leg A high side on while its input was high");
   chk_leg_b_follow: assert property (
      $rose(hsSwitchLegB) && !hsSwitchLegA |-> !$past(dirInputB))
      else $error("leg B high side on while its input was high");
   chk_high_needs_enable: assert property (
      $rose(hsSwitchLegA | hsSwitchLegB) |-> $past(enable))
      else $error("high side driven with enable low");
   chk_brake_low_sides: assert property (
      $rose(lsSwitchLegA & lsSwitchLegB) |-> $past(!dirInputA & !dirInputB))
      else $error("low side brake without both inputs low");
   chk_no_shoot: assert property (
      !(hsSwitchLegA & lsSwitchLegA) && !(hsSwitchLegB & lsSwitchLegB))
      else $error("both switches of one leg on");
   chk_dead_gap: assert property ($rose(anyOn) |-> offLen_ff >= DEAD_CYC)
      else $error("switches came on before the dead time ran out");
   chk_fault_off: assert property (!faultN |-> !anyOn)
      else $error("switch on while fault is latched");
   chk_fault_hold: assert property (!faultN |=> !faultN)
      else $error("fault released without reset");
   chk_reset_clear: assert property ($rose(rst_n) |-> faultN && !anyOn)
      else $error("fault or switch active at reset release");
   chk_pulse_width: assert property (
      $changed(enable) |-> runLen_ff >= MINP - 1)
      else $error("enable level held too briefly");
endmodule // hbdfl_asserts

// ===== sim/tb_top.sv
`timescale 1ns/1ns
// Drives both ends of the bridge pair and judges what comes back.
module tb_top;
   logic sys_clk, rst_n, supplyRampN, cmdPwm, faultSeenN; // Host side.
   hbdfl_pkg::hbdfl_mode_t cmdMode;                      // Requested mode.
   logic supplyLow, outShortDet, senseOverThr, senseShorted; // Detectors.
   logic overheatDet, currentAtLimit;                    // More detectors.
   logic hsSwitchLegA, lsSwitchLegA, hsSwitchLegB, lsSwitchLegB; // Drive.
   int miscompares = 0, checked = 0;                     // Tallies.
   bit seenOff;                                          // Gap observed.
   // Expected switches {hsA,lsA,hsB,lsB} and pins {A,B} by mode.
   localparam logic [3:0] EXP_SW [5] = '{4'h0, 4'h6, 4'h9, 4'h5, 4'hA};
   localparam logic [3:0] EXP_AB [5] = '{4'h3, 4'h2, 4'h1, 4'h0, 4'h3};
   wire [3:0] sw = {hsSwitchLegA, lsSwitchLegA, hsSwitchLegB, lsSwitchLegB};
   hbdfl_if pins ();
   hbdfl_host i_hbdfl_host (.sys_clk, .rst_n, .supplyRampN, .cmdMode,
      .cmdPwm, .faultSeenN, .pins(pins));
   // Short counts keep the run brief; expectations use the same values.
   hbdfl_device #(.DEAD_CYC(2), .SC_WIDTH_CYC(4), .CHOP_OFF_CYC(3))
      i_hbdfl_device (.sys_clk, .rst_n, .supplyLow, .outShortDet,
      .senseOverThr, .senseShorted, .overheatDet, .currentAtLimit,
      .hsSwitchLegA, .lsSwitchLegA, .hsSwitchLegB, .lsSwitchLegB,
      .pins(pins));
   hbdfl_asserts #(.DEAD_CYC(2)) i_hbdfl_asserts (.sys_clk, .rst_n,
      .dirInputA(pins.dirInputA), .dirInputB(pins.dirInputB),
      .enable(pins.enable), .faultN(pins.faultN), .hsSwitchLegA,
      .lsSwitchLegA, .hsSwitchLegB, .lsSwitchLegB);
   // Clock of 40 ns period.
   initial begin
      sys_clk = 0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Compares one value and tallies the outcome.
   task automatic cmp(input logic [3:0] got, exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits a bounded time for a switch pattern, noting any all-off cycle.
   task automatic waitSw(input logic [3:0] exp);
      seenOff = 0;
      repeat (80) begin
         @(negedge sys_clk);
         if (sw === 4'h0) seenOff = 1;
         if (sw === exp) break;
      end
   endtask
   task automatic go(input int m);
      @(posedge sys_clk);
      cmdMode <= hbdfl_pkg::hbdfl_mode_t'(m);
   endtask
   task automatic doReset();
      @(posedge sys_clk);
      rst_n <= 0;
      cmdMode <= hbdfl_pkg::HBDFL_STOP;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1;
      @(negedge sys_clk);
      cmp(pins.faultN, 1);
   endtask
   // Every mode in turn; each change must pass through all-off.
   task automatic t_modes();
      for (int m = 0; m < 5; m++) begin
         go(m);
         waitSw(EXP_SW[m]);
         cmp(sw, EXP_SW[m]);
         cmp(seenOff, 1);
         cmp({pins.dirInputA, pins.dirInputB}, EXP_AB[m]);
         if (m != 3) cmp(pins.enable, m != 0);
      end
   endtask
   // Enable carries the PWM level and gates the bridge.
   task automatic t_pwm();
      go(1);
      waitSw(4'h6);
      cmp(sw, 4'h6);
      repeat (2) begin
         @(posedge sys_clk);
         cmdPwm <= 0;
         waitSw(4'h0);
         cmp(sw, 4'h0);
         cmp(pins.enable, 0);
         @(posedge sys_clk);
         cmdPwm <= 1;
         waitSw(4'h6);
         cmp(sw, 4'h6);
      end
   endtask
   // Current at the limit briefly chops the driving low side.
   task automatic t_chop();
      @(posedge sys_clk);
      currentAtLimit <= 1;
      @(posedge sys_clk);
      currentAtLimit <= 0;
      waitSw(4'h2);
      cmp(sw, 4'h2);
      waitSw(4'h6);
      cmp(sw, 4'h6);
   endtask
   // A shorted sense resistor masks the overcurrent trip.
   task automatic t_noTrip();
      @(posedge sys_clk);
      {senseShorted, senseOverThr} <= 2'h3;
      repeat (20) @(negedge sys_clk);
      cmp(pins.faultN, 1);
      cmp(sw, 4'h6);
      @(posedge sys_clk);
      {senseShorted, senseOverThr} <= 2'h0;
   endtask
   // A ramping supply forces enable low.
   task automatic t_ramp();
      @(posedge sys_clk);
      supplyRampN <= 0;
      waitSw(4'h0);
      cmp(pins.enable, 0);
      @(posedge sys_clk);
      supplyRampN <= 1;
   endtask
   // Each detector latches the bridge off; only reset frees it.
   task automatic t_faults();
      for (int k = 0; k < 4; k++) begin
         doReset();
         go(1);
         waitSw(4'h6);
         @(posedge sys_clk);
         {overheatDet, senseOverThr, supplyLow, outShortDet} <= 4'h8 >> k;
         repeat (20) @(negedge sys_clk) if (pins.faultN === 1'b0) break;
         cmp(pins.faultN, 0);
         cmp(sw, 4'h0);
         @(posedge sys_clk);
         {overheatDet, senseOverThr, supplyLow, outShortDet} <= 4'h0;
         go(2);
         repeat (30) @(negedge sys_clk);
         cmp(pins.faultN, 0);
         cmp(faultSeenN, 0);
         cmp(sw, 4'h0);
      end
      doReset();
   endtask
   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Watchdog well beyond the several hundred cycles the run needs.
   initial begin
      #400000;
      miscompares++;
      summarize();
   end
   // Main sequence.
   initial begin
      {rst_n, supplyRampN, cmdPwm, supplyLow, outShortDet} = 5'h0C;
      {senseOverThr, senseShorted, overheatDet, currentAtLimit} = 4'h0;
      cmdMode = hbdfl_pkg::HBDFL_STOP;
      doReset();
      t_modes();
      t_pwm();
      t_chop();
      t_noTrip();
      t_ramp();
      t_faults();
      summarize();
   end
endmodule // tb_top
